// ==== inc/ubrx_links.sv ====
// Purpose: carriers between the top, the bit timer and the FIFO memory
// Assumes: all signals on sys_clk
// Notes: none
`timescale 1ns/10ps
interface ubrx_timer_if;
  logic enable;
  logic restart;
  logic [15:0] divisor;
  logic [2:0] trim;
  logic rangeSel;
  logic bitEnd;
  logic [2:0] sample;
  modport ctl (output enable, restart, divisor, trim, rangeSel, input bitEnd, sample);
  modport timer (input enable, restart, divisor, trim, rangeSel, output bitEnd, sample);
endinterface

interface ubrx_mem_if #(parameter int WIDTH = 8, parameter int DEPTH = 4);
  logic wrEn;
  logic [$clog2(DEPTH)-1:0] wrAddr;
  logic [WIDTH-1:0] wrData;
  logic [$clog2(DEPTH)-1:0] rdAddr;
  logic [WIDTH-1:0] rdData;
  modport ctl (output wrEn, wrAddr, wrData, rdAddr, input rdData);
  modport mem (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface

// ==== inc/ubrx_pkg.sv ====
// Purpose: shared constants and types of the baud timer and receive FIFO block
// Assumes: 32-bit Avalon-MM register slave, byte addresses, one register per word
// Notes: all registers sit in the low 8-bit lane, unused and upper bits read zero
package ubrx_pkg;
  // register byte addresses
  localparam logic [4:0] ADDR_DIV_LOW = 5'h00;
  localparam logic [4:0] ADDR_DIV_HIGH = 5'h04;
  localparam logic [4:0] ADDR_FIFO_CTRL = 5'h08;
  localparam logic [4:0] ADDR_FILL = 5'h0C;
  localparam logic [4:0] ADDR_CTRL = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;
  localparam logic [4:0] ADDR_RX_DATA = 5'h18;
  // field positions
  localparam int FCR_THR_LSB = 0;
  localparam int FCR_RANGE_BIT = 2;
  localparam int FCR_TRIM_LSB = 3;
  localparam int FCR_USED_BITS = 6;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_IRQ_EN_BIT = 1;
  localparam int STAT_AVAIL_BIT = 0;
  localparam int STAT_OVERRUN_BIT = 1;
  // reset values
  localparam logic [7:0] DIV_LOW_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  localparam logic [7:0] FIFO_CTRL_RESET = 8'h00;
  // sizes
  localparam int FIFO_DEPTH = 4;
  localparam int DATA_BITS = 8;
  localparam int TRIM_BITS = 3;
  // receiver sequencing
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubrx_rx_state_t;
  // bus answer phases
  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} ubrx_bus_phase_t;
endpackage

// ==== logic/ubrx_bit_timer.sv ====
// Purpose: free running bit timer with fractional trim and three sample strobes
// Assumes: divisor at least 8, trim below 8
// Notes: strobes and bitEnd are registered one cycle after the count they decode
`timescale 1ns/10ps
module ubrx_bit_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // control and strobes
  ubrx_timer_if.timer tmr
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] lastIdx;
    logic [3:0] acc;
    logic extra;
    logic bitEnd;
    logic [2:0] sample;
  } ubrx_timer_state_t;

  ubrx_timer_state_t st;
  ubrx_timer_state_t next_st;

  // counter, accumulator and sample point decode
  always_comb begin
    logic [15:0] half;
    logic [15:0] pos [3];
    logic [3:0] accBase;
    logic [3:0] lowSum;
    half = {1'b0, tmr.divisor[15:1]};
    pos[0] = tmr.rangeSel ? half - 16'h0001 : half;
    pos[1] = tmr.rangeSel ? half : half + 16'h0001;
    pos[2] = half + 16'h0002;
    accBase = tmr.restart ? 4'h0 : st.acc; // frame start adds from zero
    lowSum = {1'b0, accBase[2:0]} + {1'b0, tmr.trim};
    next_st = st;
    next_st.bitEnd = 1'b0;
    if (!tmr.enable) begin
      next_st.cnt = 16'h0000;
      next_st.acc = 4'h0;
      next_st.extra = 1'b0;
      next_st.lastIdx = tmr.divisor - 16'h0001;
    end else if (tmr.restart || st.cnt == st.lastIdx) begin
      // one addition per bit time, the low carry stretches this bit by one clock
      next_st.cnt = 16'h0000;
      next_st.acc = accBase + {1'b0, tmr.trim};
      next_st.extra = lowSum[3];
      next_st.lastIdx = tmr.divisor - 16'h0001 + {15'h0000, lowSum[3]};
      next_st.bitEnd = !tmr.restart;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
    for (int i = 0; i < 3; i++) begin
      next_st.sample[i] = tmr.enable && !tmr.restart && st.cnt == pos[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tmr.bitEnd = st.bitEnd;
  assign tmr.sample = st.sample;

  chk_bit_period: assert property (@(posedge sys_clk) disable iff (srst)
    st.bitEnd |-> st.lastIdx == tmr.divisor - 16'h0001 + {15'h0000, st.extra})
    else $error("bit period does not match divisor and carry");
  chk_carry_extra: assert property (@(posedge sys_clk) disable iff (srst)
    st.bitEnd && tmr.enable |-> st.extra == (st.acc[2:0] < tmr.trim))
    else $error("extra clock not tied to accumulator carry");
  chk_acc_restart: assert property (@(posedge sys_clk) disable iff (srst)
    tmr.restart && tmr.enable |=> st.acc == {1'b0, $past(tmr.trim)})
    else $error("accumulator not cleared at frame start");
  // a restart or range change around the strobes moves them on purpose, so keep those out
  chk_samples_low: assert property (@(posedge sys_clk) disable iff (srst)
    tmr.enable && !tmr.restart && !tmr.rangeSel
      ##1 st.sample[0] && tmr.enable && !tmr.restart && !tmr.rangeSel
      ##1 tmr.enable && !tmr.restart
      |-> st.sample[1] ##1 st.sample[2])
    else $error("range 0 sample spacing wrong");
  chk_samples_high: assert property (@(posedge sys_clk) disable iff (srst)
    tmr.enable && !tmr.restart && tmr.rangeSel
      ##1 st.sample[0] && tmr.enable && !tmr.restart && tmr.rangeSel
      ##1 tmr.enable && !tmr.restart ##1 tmr.enable && !tmr.restart
      |-> $past(st.sample[1]) ##1 st.sample[2])
    else $error("range 1 sample spacing wrong");
endmodule

// ==== logic/ubrx_fifo_mem.sv ====
// Purpose: small receive byte store with a registered read port
// Assumes: one write and one read address per cycle
// Notes: read data lag the read address by one cycle, contents are not reset
`timescale 1ns/10ps
module ubrx_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock
  input wire logic sys_clk,
  // access port
  ubrx_mem_if.mem port
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0] rdData;
  } ubrx_mem_state_t;

  ubrx_mem_state_t st;
  ubrx_mem_state_t next_st;

  // write a cell, read through a register
  always_comb begin
    next_st = st;
    if (port.wrEn) begin
      next_st.cells[port.wrAddr] = port.wrData;
    end
    next_st.rdData = st.cells[port.rdAddr];
  end

  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  assign port.rdData = st.rdData;
endmodule

// ==== logic/ubrx_top.sv ====
// Purpose: baud generator, receiver and receive FIFO level logic with register slave
// Assumes: rxLine is asynchronous, software keeps the divisor in its legal range
// Notes: every bus access answers with waitrequest low two cycles after it appears
`timescale 1ns/10ps

module ubrx_top #(
  parameter int FIFO_DEPTH = ubrx_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial line and request
  input wire logic rxLine,
  output logic irqRequest
);
  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam logic [2:0] FULL_FILL = 3'(FIFO_DEPTH);

  typedef struct packed {
    logic rxSync1;
    logic rxSync2;
    logic rxPrev;
    ubrx_pkg::ubrx_rx_state_t rxState;
    logic [2:0] bitIdx;
    logic [1:0] votes;
    logic [7:0] shifter;
    logic held;
    logic [7:0] heldByte;
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [2:0] fill;
    logic [7:0] divLow;
    logic [15:0] divisor;
    logic [7:0] fifoCtrl;
    logic enable;
    logic irqEnable;
    logic rxAvail;
    logic overrun;
    logic irq;
    logic restart;
    ubrx_pkg::ubrx_bus_phase_t phase;
    logic waitreq;
    logic [31:0] readdata;
  } ubrx_top_state_t;

  ubrx_top_state_t st;
  ubrx_top_state_t next_st;

  ubrx_timer_if tmr ();
  ubrx_mem_if #(.WIDTH(ubrx_pkg::DATA_BITS), .DEPTH(FIFO_DEPTH)) mem ();

  logic act;
  logic busWr;
  logic divHighWr;
  logic pop;
  logic push;
  logic byteDone;
  logic [7:0] pushData;

  // the access is carried out in the wait phase, the master still holds it
  assign act = st.phase == ubrx_pkg::BUS_WAIT && (avs_read || avs_write);
  assign busWr = act && avs_write && avs_byteenable[0];
  assign divHighWr = busWr && avs_address == ubrx_pkg::ADDR_DIV_HIGH;
  // reading an empty FIFO returns zero and leaves the count alone
  assign pop = act && avs_read && avs_address == ubrx_pkg::ADDR_RX_DATA && st.fill != 3'h0;

  // threshold code 0 means a full FIFO, other codes mean that many or more
  function automatic logic ubrx_meets(input logic [2:0] fill, input logic [1:0] thr);
    if (thr == 2'h0) begin
      return fill == FULL_FILL;
    end
    return fill >= {1'b0, thr};
  endfunction

  // bus phases, registers, receiver and FIFO bookkeeping
  always_comb begin
    logic [7:0] wd;
    logic room;
    logic clearAll;
    logic maj;
    wd = avs_writedata[7:0];
    room = st.fill != FULL_FILL;
    clearAll = !st.enable;
    maj = st.votes[1];
    next_st = st;
    next_st.restart = 1'b0;
    byteDone = 1'b0;
    push = 1'b0;
    pushData = st.shifter;
    // two flops before the line is looked at
    next_st.rxSync1 = rxLine;
    next_st.rxSync2 = st.rxSync1;
    next_st.rxPrev = st.rxSync2;

    // answer phases: take, act and drop waitrequest, then release
    case (st.phase)
      ubrx_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_st.phase = ubrx_pkg::BUS_WAIT;
        end
      end
      ubrx_pkg::BUS_WAIT: begin
        next_st.phase = ubrx_pkg::BUS_DONE;
        next_st.waitreq = 1'b0;
      end
      ubrx_pkg::BUS_DONE: begin
        next_st.phase = ubrx_pkg::BUS_IDLE;
        next_st.waitreq = 1'b1;
      end
      default: begin
        next_st.phase = ubrx_pkg::BUS_IDLE;
        next_st.waitreq = 1'b1;
      end
    endcase

    // register writes; the low byte is only staged until the high byte lands
    if (busWr) begin
      case (avs_address)
        ubrx_pkg::ADDR_DIV_LOW: begin
          next_st.divLow = wd;
        end
        ubrx_pkg::ADDR_DIV_HIGH: begin
          next_st.divisor = {wd, st.divLow};
        end
        ubrx_pkg::ADDR_FIFO_CTRL: begin
          next_st.fifoCtrl = {2'b00, wd[ubrx_pkg::FCR_USED_BITS-1:0]};
        end
        ubrx_pkg::ADDR_CTRL: begin
          next_st.enable = wd[ubrx_pkg::CTRL_ENABLE_BIT];
          next_st.irqEnable = wd[ubrx_pkg::CTRL_IRQ_EN_BIT];
          // turning the unit on starts from an empty FIFO
          if (wd[ubrx_pkg::CTRL_ENABLE_BIT] && !st.enable) begin
            clearAll = 1'b1;
          end
        end
        ubrx_pkg::ADDR_STATUS: begin
          // write one clears overrun; a set in the same cycle wins below
          if (wd[ubrx_pkg::STAT_OVERRUN_BIT]) begin
            next_st.overrun = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // read answers; unmapped addresses and upper bits read zero
    if (act && avs_read) begin
      next_st.readdata = 32'h0000_0000;
      case (avs_address)
        ubrx_pkg::ADDR_DIV_LOW: next_st.readdata[7:0] = st.divLow;
        ubrx_pkg::ADDR_DIV_HIGH: next_st.readdata[7:0] = st.divisor[15:8];
        ubrx_pkg::ADDR_FIFO_CTRL: next_st.readdata[7:0] = st.fifoCtrl;
        ubrx_pkg::ADDR_FILL: next_st.readdata[2:0] = st.fill;
        ubrx_pkg::ADDR_CTRL: begin
          next_st.readdata[ubrx_pkg::CTRL_ENABLE_BIT] = st.enable;
          next_st.readdata[ubrx_pkg::CTRL_IRQ_EN_BIT] = st.irqEnable;
        end
        ubrx_pkg::ADDR_STATUS: begin
          next_st.readdata[ubrx_pkg::STAT_AVAIL_BIT] = st.rxAvail;
          next_st.readdata[ubrx_pkg::STAT_OVERRUN_BIT] = st.overrun;
        end
        ubrx_pkg::ADDR_RX_DATA: begin
          if (st.fill != 3'h0) begin
            next_st.readdata[7:0] = mem.rdData;
          end
        end
        default: begin
        end
      endcase
    end

    // receiver: start edge, three votes per bit, eight data bits lsb first
    if (st.enable) begin
      if (tmr.sample != 3'h0) begin
        next_st.votes = st.votes + {1'b0, st.rxSync2};
      end
      case (st.rxState)
        ubrx_pkg::RX_IDLE: begin
          if (st.rxPrev && !st.rxSync2) begin
            next_st.restart = 1'b1;
            next_st.votes = 2'h0;
            next_st.rxState = ubrx_pkg::RX_START;
          end
        end
        ubrx_pkg::RX_START: begin
          // a stale bit end from the free running timer lands with the restart
          if (tmr.bitEnd && !st.restart) begin
            next_st.votes = 2'h0;
            next_st.bitIdx = 3'h0;
            // a high majority was a glitch, not a start bit
            next_st.rxState = maj ? ubrx_pkg::RX_IDLE : ubrx_pkg::RX_DATA;
          end
        end
        ubrx_pkg::RX_DATA: begin
          if (tmr.bitEnd) begin
            next_st.votes = 2'h0;
            next_st.shifter = {maj, st.shifter[7:1]};
            next_st.bitIdx = st.bitIdx + 3'h1;
            if (st.bitIdx == 3'h7) begin
              next_st.rxState = ubrx_pkg::RX_STOP;
            end
          end
        end
        ubrx_pkg::RX_STOP: begin
          // finish at the last stop sample so a back-to-back start edge is seen
          if (tmr.sample[2]) begin
            byteDone = 1'b1;
            next_st.rxState = ubrx_pkg::RX_IDLE;
          end
        end
        default: begin
          next_st.rxState = ubrx_pkg::RX_IDLE;
        end
      endcase
    end

    // a byte goes to the FIFO if there is room and no byte is held, else it waits in heldByte
    if (byteDone) begin
      if (room && !st.held) begin
        push = 1'b1;
      end else if (!st.held) begin
        next_st.held = 1'b1;
        next_st.heldByte = st.shifter;
      end else begin
        next_st.heldByte = st.shifter;
        next_st.overrun = 1'b1;
      end
    end else if (st.held && room) begin
      push = 1'b1;
      pushData = st.heldByte;
      next_st.held = 1'b0;
    end

    // count follows stores and reads, never passes the depth
    next_st.fill = st.fill + {2'b00, push} - {2'b00, pop};
    if (push) begin
      next_st.wrPtr = st.wrPtr + PTR_W'(1);
    end
    if (pop) begin
      next_st.rdPtr = st.rdPtr + PTR_W'(1);
    end

    // level flag and request are registered copies of their causes
    next_st.rxAvail = st.enable &&
      ubrx_meets(st.fill, st.fifoCtrl[ubrx_pkg::FCR_THR_LSB +: 2]);
    next_st.irq = st.irqEnable && (st.rxAvail || st.overrun);

    // disabled unit holds buffers and flags empty, settings are kept
    if (clearAll) begin
      next_st.fill = 3'h0;
      next_st.wrPtr = '0;
      next_st.rdPtr = '0;
      next_st.held = 1'b0;
      next_st.rxAvail = 1'b0;
      next_st.overrun = 1'b0;
      next_st.rxState = ubrx_pkg::RX_IDLE;
      push = 1'b0;
    end
  end

  // reset empties the FIFO and parks the line synchroniser high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
      st.rxSync1 <= 1'b1;
      st.rxSync2 <= 1'b1;
      st.rxPrev <= 1'b1;
      st.divLow <= ubrx_pkg::DIV_LOW_RESET;
      st.divisor <= ubrx_pkg::DIVISOR_RESET;
      st.fifoCtrl <= ubrx_pkg::FIFO_CTRL_RESET;
      st.waitreq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // timer and memory hookup
  assign tmr.enable = st.enable;
  assign tmr.restart = st.restart;
  assign tmr.divisor = st.divisor;
  assign tmr.trim = st.fifoCtrl[ubrx_pkg::FCR_TRIM_LSB +: ubrx_pkg::TRIM_BITS];
  assign tmr.rangeSel = st.fifoCtrl[ubrx_pkg::FCR_RANGE_BIT];
  assign mem.wrEn = push;
  assign mem.wrAddr = st.wrPtr;
  assign mem.wrData = pushData;
  assign mem.rdAddr = st.rdPtr;

  ubrx_bit_timer u_timer (
    .sys_clk(sys_clk),
    .srst(srst),
    .tmr(tmr)
  );

  ubrx_fifo_mem #(.WIDTH(ubrx_pkg::DATA_BITS), .DEPTH(FIFO_DEPTH)) u_mem (
    .sys_clk(sys_clk),
    .port(mem)
  );

  // outputs straight from the state register
  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitreq;
  assign irqRequest = st.irq;

  chk_fill_bound: assert property (@(posedge sys_clk) disable iff (srst)
    st.fill <= FULL_FILL)
    else $error("fill count above depth");
  chk_fill_reset: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> st.fill == 3'h0 && !st.held)
    else $error("FIFO not empty after reset");
  chk_fill_step: assert property (@(posedge sys_clk) disable iff (srst)
    st.enable && push && !pop |=> st.fill == $past(st.fill) + 3'h1 || !$past(next_st.enable))
    else $error("fill count did not rise on store");
  chk_fill_drop: assert property (@(posedge sys_clk) disable iff (srst)
    st.enable && pop && !push && !busWr |=> st.fill == $past(st.fill) - 3'h1)
    else $error("fill count did not fall on read");
  chk_avail_full: assert property (@(posedge sys_clk) disable iff (srst)
    st.enable && st.fill == FULL_FILL ##1 st.enable |-> st.rxAvail)
    else $error("receive-available missing at full FIFO");
  chk_avail_empty: assert property (@(posedge sys_clk) disable iff (srst)
    st.fill == 3'h0 |=> !st.rxAvail)
    else $error("receive-available set with empty FIFO");
  chk_irq_cause: assert property (@(posedge sys_clk) disable iff (srst)
    irqRequest |-> $past(st.irqEnable && (st.rxAvail || st.overrun)))
    else $error("interrupt without enabled cause");
  chk_irq_follow: assert property (@(posedge sys_clk) disable iff (srst)
    st.irqEnable && st.overrun |=> irqRequest)
    else $error("overrun did not raise interrupt");
  chk_disable_clear: assert property (@(posedge sys_clk) disable iff (srst)
    !st.enable ##1 !st.enable |-> st.fill == 3'h0 && !st.rxAvail && !st.overrun)
    else $error("disabled unit kept receive state");
  chk_upper_zero: assert property (@(posedge sys_clk) disable iff (srst)
    !avs_waitrequest && avs_read && avs_address == ubrx_pkg::ADDR_FILL
      |-> avs_readdata[31:3] == 29'h0000_0000)
    else $error("fill register upper bits not zero");
  chk_div_commit: assert property (@(posedge sys_clk) disable iff (srst)
    st.divisor != $past(st.divisor) |-> $past(divHighWr))
    else $error("divisor changed without high byte write");
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the baud timer and receive FIFO level logic
// Assumes: slave answers each access after a fixed delay, partner sends frames
// Notes: divisor 17 with trim 3 keeps the fractional stretch in every frame
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic rxLine;
  logic irqRequest;
  int fails = 0;
  int comparisons = 0;
  logic [7:0] pat [6] = '{8'h01, 8'h80, 8'hA5, 8'h3C, 8'hFF, 8'h96};

  // 250 MHz
  always #2 sys_clk = ~sys_clk;

  ubrx_top u_dut (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(4'hF),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .rxLine(rxLine),
    .irqRequest(irqRequest)
  );
  ubrx_line_partner u_partner (.sys_clk(sys_clk), .rxLine(rxLine));

  // one access; values read just after the edge are the ones sampled at it
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= {24'h0, d};
    @(posedge sys_clk);
    // only the watchdog ends a wait that never answers
    while (avsWaitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    // one idle edge so no strobe is driven twice in a time step
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(q, {24'h0, e})
  endtask

  task automatic t_reset();
    rdChk(ubrx_pkg::ADDR_DIV_LOW, 8'h00);
    rdChk(ubrx_pkg::ADDR_FIFO_CTRL, 8'h00);
    rdChk(ubrx_pkg::ADDR_FILL, 8'h00);
    wr(ubrx_pkg::ADDR_FILL, 8'hFF);
    rdChk(ubrx_pkg::ADDR_FILL, 8'h00);
    wr(ubrx_pkg::ADDR_FIFO_CTRL, 8'hFF);
    rdChk(ubrx_pkg::ADDR_FIFO_CTRL, 8'h3F);
    rdChk(5'h1C, 8'h00);
  endtask

  // each fill level from one to four against every threshold code, irq following the flag
  task automatic t_levels();
    logic av;
    wr(ubrx_pkg::ADDR_DIV_LOW, 8'h11);
    wr(ubrx_pkg::ADDR_DIV_HIGH, 8'h00);
    // trim 3 and range 1 before enabling, so the first frame uses the early sample set
    wr(ubrx_pkg::ADDR_FIFO_CTRL, 8'h1C);
    wr(ubrx_pkg::ADDR_CTRL, 8'h03);
    for (int k = 0; k < 4; k++) begin
      u_partner.send(pat[k], 17, 3'd3);
      rdChk(ubrx_pkg::ADDR_FILL, 8'(k + 1));
      for (int t = 0; t < 4; t++) begin
        av = (k + 1) >= ((t == 0) ? 4 : t);
        wr(ubrx_pkg::ADDR_FIFO_CTRL, 8'h18 | 8'(t));
        rdChk(ubrx_pkg::ADDR_STATUS, {7'h0, av});
        `CHK(irqRequest, av)
      end
    end
  endtask

  // fifth byte waits, sixth replaces it, count stays at four
  task automatic t_overflow();
    u_partner.send(pat[4], 17, 3'd3);
    u_partner.send(pat[5], 17, 3'd3);
    rdChk(ubrx_pkg::ADDR_FILL, 8'h04);
    rdChk(ubrx_pkg::ADDR_STATUS, 8'h03);
    for (int k = 0; k < 5; k++) begin
      rdChk(ubrx_pkg::ADDR_RX_DATA, (k < 4) ? pat[k] : pat[5]);
    end
    rdChk(ubrx_pkg::ADDR_FILL, 8'h00);
    `CHK(irqRequest, 1'b1)
  endtask

  task automatic t_disable();
    u_partner.send(pat[2], 17, 3'd3);
    wr(ubrx_pkg::ADDR_CTRL, 8'h00);
    rdChk(ubrx_pkg::ADDR_FILL, 8'h00);
    rdChk(ubrx_pkg::ADDR_STATUS, 8'h00);
    `CHK(irqRequest, 1'b0)
    rdChk(ubrx_pkg::ADDR_FIFO_CTRL, 8'h1B);
    rdChk(ubrx_pkg::ADDR_DIV_LOW, 8'h11);
    wr(ubrx_pkg::ADDR_CTRL, 8'h03);
    rdChk(ubrx_pkg::ADDR_FILL, 8'h00);
  endtask

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_levels();
    t_overflow();
    t_disable();
    summarize();
  end

  // seven frames and about sixty accesses fit well inside this span
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule

// ==== tb/ubrx_line_partner.sv ====
// Purpose: remote serial transmitter that drives the receive line
// Assumes: 8N1 frames, LSB first, the line idles high
// Notes: bit times follow the same eighths accumulator as the receiver
`timescale 1ns/10ps
module ubrx_line_partner (
  // clock
  input wire logic sys_clk,
  // serial line
  output logic rxLine
);
  initial rxLine = 1'b1;

  // one frame; the accumulator restarts at the start bit, so both ends stay in step
  task automatic send(input logic [7:0] b, input int div, input logic [2:0] trim);
    logic [9:0] bits;
    logic [3:0] acc;
    bits = {1'b1, b, 1'b0};
    acc = 4'h0;
    for (int i = 0; i < 10; i++) begin
      acc = acc + {1'b0, trim};
      rxLine <= bits[i];
      repeat (div + int'(acc[3])) @(posedge sys_clk);
      acc[3] = 1'b0;
    end
    // idle gap lets the stop-bit samples and the store land
    repeat (8) @(posedge sys_clk);
  endtask
endmodule
